/* File: sarc_adc_controller.sv */
// control logic of a 10-bit successive-approximation converter
// assumes an analog sample-hold, resistor string and comparator outside
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`include "sarc_consts.svh"
module sarc_adc_controller #(
  parameter int NUM_CH = 8,
  parameter int CH_W = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire sarc_pkg::sarc_bus_req_s busReq,
  output logic [15:0] busRdata,
  output logic busWait,
  input wire logic compResultAsync,
  output logic sampleHold,
  output logic comparatorPower,
  output sarc_pkg::sarc_code_t trialCode,
  output logic [NUM_CH-1:0] channelOneHot,
  output logic [NUM_CH-1:0] pinAnalogMode,
  output logic [NUM_CH-1:0] pinFunction,
  output logic [NUM_CH-1:0] pinDirection,
  output logic conversionDoneIrq
);

  // ----------------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------------
  localparam int SETTLE_CYC = (`SARC_COMP_SETTLE_NS * `SARC_CLK_MHZ
    + `SARC_NS_PER_US - 1) / `SARC_NS_PER_US;
  localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);
  localparam logic [5:0] SAMPLE_LV0 = 6'(`SARC_FAD_LEN_LV0
    - `SARC_RES_BITS - `SARC_LOAD_STEPS);
  localparam logic [5:0] SAMPLE_LV1 = 6'(`SARC_FAD_LEN_LV1
    - `SARC_RES_BITS - `SARC_LOAD_STEPS);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // conversion clock divisor for a frequency-select code
  function automatic logic [4:0] freqDivisor(input logic [3:0] fr);
    logic [4:0] d;
    d = `SARC_DIV_FR3;
    if (!fr[3])
    begin
      unique case (fr[2:0])
        3'h0: d = `SARC_DIV_0000;
        3'h1: d = `SARC_DIV_0001;
        3'h2: d = `SARC_DIV_0010;
        3'h3: d = `SARC_DIV_0011;
        3'h4: d = `SARC_DIV_0100;
        3'h5: d = `SARC_DIV_0101;
        // prohibited codes fall back to the slowest clock
        default: d = `SARC_DIV_FR3;
      endcase
    end
    return d;
  endfunction

  // address match used by read and write decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction

  // ----------------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------------
  logic [7:0] converter_mode_reg; // run, timing, comparator control
  logic [CH_W-1:0] channel_select_reg; // channel to convert
  logic [NUM_CH-1:0] pin_analog_config_reg; // 1 = pin analog
  logic [NUM_CH-1:0] pin_function_reg; // 1 = segment output
  logic [NUM_CH-1:0] pin_direction_reg; // 1 = input
  logic [15:0] result_wide_reg; // left-aligned result
  logic [7:0] result_high_byte_reg; // upper result byte
  sarc_pkg::sarc_code_t approximation_reg; // trial and decided bits
  sarc_pkg::sarc_state_e state_reg; // sequencer state
  logic [3:0] bitIdx_reg; // bit under decision
  logic [5:0] sampleCnt_reg; // sample steps left
  logic [SETTLE_W-1:0] settleCnt_reg; // comparator warm-up count
  logic startSuspect_reg; // this conversion began unsettled
  logic resultSuspect_reg; // last loaded result is unreliable
  logic compMeta_reg; // synchroniser first stage
  logic compSync_reg; // synchronised comparator decision
  logic [7:0] modeNext; // mode after a masked write
  logic runBit; // conversion enabled
  logic cmpBit; // comparator enabled
  logic compSettled; // comparator past warm-up
  logic stepTick; // one conversion-clock step done
  logic [4:0] stepDivisor; // selected divisor

  assign runBit = converter_mode_reg[`SARC_MODE_RUN];
  assign cmpBit = converter_mode_reg[`SARC_MODE_CMP];
  assign compSettled = cmpBit && (settleCnt_reg == SETTLE_W'(SETTLE_CYC));
  assign stepDivisor = freqDivisor(
    converter_mode_reg[`SARC_MODE_FR_HI:`SARC_MODE_FR_LO]);
  // bit and byte writes merge through the mask
  assign modeNext = (converter_mode_reg & ~busReq.wmask)
    | (busReq.wdata[7:0] & busReq.wmask);

  // ----------------------------------------------------------------------
  // conversion clock
  // ----------------------------------------------------------------------
  sarc_step_timer #(
    .DIV_W(5)
  ) u_step (
    .clk(clk),
    .reset(reset),
    .clkEn(clkEn),
    .run(runBit),
    .divisor(stepDivisor),
    .tick(stepTick)
  );

  // ----------------------------------------------------------------------
  // comparator input synchroniser
  // ----------------------------------------------------------------------
  // two stages; only the second is read by logic
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      compMeta_reg <= 1'b0;
      compSync_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      compMeta_reg <= compResultAsync;
      compSync_reg <= compMeta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // control register writes
  // ----------------------------------------------------------------------
  // result addresses are not decoded for writes, so writes fall away
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      converter_mode_reg <= `SARC_RST_MODE;
      channel_select_reg <= `SARC_RST_CHAN;
      pin_analog_config_reg <= `SARC_RST_PINCFG;
      pin_function_reg <= `SARC_RST_PINFUNC;
      pin_direction_reg <= `SARC_RST_PINDIR;
    end
    else if (clkEn && busReq.wr)
    begin
      if (hit(busReq.addr, `SARC_ADDR_MODE))
        converter_mode_reg <= modeNext;
      if (hit(busReq.addr, `SARC_ADDR_CHAN))
        channel_select_reg <= busReq.wdata[CH_W-1:0];
      if (hit(busReq.addr, `SARC_ADDR_PINCFG))
        pin_analog_config_reg <= busReq.wdata[NUM_CH-1:0];
      if (hit(busReq.addr, `SARC_ADDR_PINFUNC))
        pin_function_reg <= busReq.wdata[NUM_CH-1:0];
      if (hit(busReq.addr, `SARC_ADDR_PINDIR))
        pin_direction_reg <= busReq.wdata[NUM_CH-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // comparator warm-up
  // ----------------------------------------------------------------------
  // counts from comparator enable up to the settle time, then stops
  always_ff @(posedge clk)
  begin
    if (reset)
      settleCnt_reg <= '0;
    else if (clkEn)
    begin
      if (!cmpBit)
        settleCnt_reg <= '0;
      else if (!compSettled)
        settleCnt_reg <= SETTLE_W'(settleCnt_reg + 1'b1);
    end
  end

  // ----------------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------------
  // sample, ten bit steps, one load step, then round again
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= sarc_pkg::ST_IDLE;
      approximation_reg <= `SARC_RST_CODE;
      bitIdx_reg <= `SARC_MSB_IDX;
      sampleCnt_reg <= '0;
      startSuspect_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!runBit)
        state_reg <= sarc_pkg::ST_IDLE;
      else
      begin
        unique case (state_reg)
          sarc_pkg::ST_IDLE:
          begin
            // start: pick sample length from the level select
            state_reg <= sarc_pkg::ST_SAMPLE;
            sampleCnt_reg <= converter_mode_reg[`SARC_MODE_LV_LO]
              ? SAMPLE_LV1 : SAMPLE_LV0;
            startSuspect_reg <= !compSettled;
          end
          sarc_pkg::ST_SAMPLE:
          begin
            if (stepTick)
            begin
              if (sampleCnt_reg == 6'h01)
              begin
                // hold and place the MSB trial
                state_reg <= sarc_pkg::ST_BITS;
                bitIdx_reg <= `SARC_MSB_IDX;
                approximation_reg <= 10'h200;
              end
              else
                sampleCnt_reg <= 6'(sampleCnt_reg - 1'b1);
            end
          end
          sarc_pkg::ST_BITS:
          begin
            if (stepTick)
            begin
              // keep or drop the trial bit, then try the next lower
              approximation_reg[bitIdx_reg] <= compSync_reg;
              if (bitIdx_reg == `SARC_LSB_IDX)
                state_reg <= sarc_pkg::ST_LOAD;
              else
              begin
                approximation_reg[4'(bitIdx_reg - 1'b1)] <= 1'b1;
                bitIdx_reg <= 4'(bitIdx_reg - 1'b1);
              end
            end
          end
          sarc_pkg::ST_LOAD:
          begin
            if (stepTick)
            begin
              // repeat on the same channel with a fresh sample
              state_reg <= sarc_pkg::ST_SAMPLE;
              sampleCnt_reg <= converter_mode_reg[`SARC_MODE_LV_LO]
                ? SAMPLE_LV1 : SAMPLE_LV0;
              startSuspect_reg <= !compSettled;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // result registers and completion pulse
  // ----------------------------------------------------------------------
  // loaded on the load step only; held while stopped
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      result_wide_reg <= 16'h0000;
      result_high_byte_reg <= 8'h00;
      resultSuspect_reg <= 1'b0;
      conversionDoneIrq <= 1'b0;
    end
    else if (clkEn)
    begin
      conversionDoneIrq <= 1'b0;
      if (runBit && state_reg == sarc_pkg::ST_LOAD && stepTick)
      begin
        result_wide_reg <= {approximation_reg,
          `SARC_RES_PAD'(0)};
        result_high_byte_reg <= approximation_reg[9:2];
        resultSuspect_reg <= startSuspect_reg;
        conversionDoneIrq <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // register reads and wait indication
  // ----------------------------------------------------------------------
  // data stand in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busRdata <= 16'h0000;
      busWait <= 1'b0;
    end
    else if (clkEn)
    begin
      busRdata <= 16'h0000;
      // result reads and mode writes insert one wait cycle
      busWait <= (busReq.rd && (hit(busReq.addr, `SARC_ADDR_RES_WIDE)
        || hit(busReq.addr, `SARC_ADDR_RES_HIGH)))
        || (busReq.wr && hit(busReq.addr, `SARC_ADDR_MODE));
      if (busReq.rd)
      begin
        if (hit(busReq.addr, `SARC_ADDR_MODE))
          busRdata <= {8'h00, converter_mode_reg};
        else if (hit(busReq.addr, `SARC_ADDR_RES_WIDE))
          busRdata <= result_wide_reg;
        else if (hit(busReq.addr, `SARC_ADDR_RES_HIGH))
          busRdata <= {8'h00, result_high_byte_reg};
        else if (hit(busReq.addr, `SARC_ADDR_CHAN))
          busRdata <= 16'(channel_select_reg);
        else if (hit(busReq.addr, `SARC_ADDR_PINCFG))
          busRdata <= 16'(pin_analog_config_reg);
        else if (hit(busReq.addr, `SARC_ADDR_PINFUNC))
          busRdata <= 16'(pin_function_reg);
        else if (hit(busReq.addr, `SARC_ADDR_PINDIR))
          busRdata <= 16'(pin_direction_reg);
        else if (hit(busReq.addr, `SARC_ADDR_STATUS))
          busRdata <= {13'h0000, state_reg != sarc_pkg::ST_IDLE,
            resultSuspect_reg, compSettled};
      end
    end
  end

  // ----------------------------------------------------------------------
  // analog side and pin control outputs
  // ----------------------------------------------------------------------
  // sample switch closed only while sampling; comparator on bit 0
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sampleHold <= 1'b0;
      comparatorPower <= 1'b0;
      trialCode <= `SARC_RST_CODE;
      channelOneHot <= '0;
    end
    else if (clkEn)
    begin
      sampleHold <= runBit && (state_reg == sarc_pkg::ST_SAMPLE);
      comparatorPower <= cmpBit;
      trialCode <= approximation_reg;
      // only the selected pin joins the sample switch, whatever its analog setting
      channelOneHot <= runBit ? NUM_CH'(1) << channel_select_reg
        : '0;
    end
  end

  assign pinAnalogMode = pin_analog_config_reg;
  assign pinFunction = pin_function_reg;
  assign pinDirection = pin_direction_reg;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  AST_IRQ_PULSE: assert property (@(posedge clk) disable iff (reset)
    conversionDoneIrq && clkEn |=> !conversionDoneIrq)
    else $error("completion pulse longer than one cycle");

  AST_WIDE_LOW_ZERO: assert property (@(posedge clk) disable iff (reset)
    result_wide_reg[5:0] == 6'h00)
    else $error("wide result low bits not zero");

  AST_HIGH_MATCH: assert property (@(posedge clk) disable iff (reset)
    result_high_byte_reg == result_wide_reg[15:8])
    else $error("high byte differs from wide result");

  AST_LOAD_WITH_IRQ: assert property (@(posedge clk)
    disable iff (reset)
    !$stable(result_wide_reg) |-> conversionDoneIrq)
    else $error("result changed without completion");

  AST_STOP_IDLE: assert property (@(posedge clk) disable iff (reset)
    !runBit && clkEn |=> state_reg == sarc_pkg::ST_IDLE && !sampleHold)
    else $error("sequencer running while stopped");

  AST_HOLD_DURING_BITS: assert property (@(posedge clk)
    disable iff (reset)
    state_reg == sarc_pkg::ST_BITS ##1 state_reg == sarc_pkg::ST_BITS
    |-> !sampleHold)
    else $error("sample switch closed during bit decisions");

  AST_MSB_FIRST: assert property (@(posedge clk) disable iff (reset)
    state_reg == sarc_pkg::ST_BITS
    && $past(state_reg) == sarc_pkg::ST_SAMPLE
    |-> bitIdx_reg == `SARC_MSB_IDX && approximation_reg[9])
    else $error("decision did not start at the top bit");

  AST_READ_WAIT: assert property (@(posedge clk) disable iff (reset)
    busReq.rd && clkEn && hit(busReq.addr, `SARC_ADDR_RES_HIGH)
    |=> busWait)
    else $error("result read without wait cycle");

  AST_MODE_WAIT: assert property (@(posedge clk) disable iff (reset)
    busReq.wr && clkEn && hit(busReq.addr, `SARC_ADDR_MODE)
    |=> busWait)
    else $error("mode write without wait cycle");

  AST_CHANNEL: assert property (@(posedge clk) disable iff (reset)
    runBit && clkEn ##1 runBit
    |-> channelOneHot == NUM_CH'(1) << $past(channel_select_reg))
    else $error("wrong channel connected");

endmodule

/* File: sarc_comp_model.sv */
// analog front-end model: sample-hold, resistor string and comparator
// assumes the controller drives the tap code and samples the decision
`timescale 1ns/10ps
module sarc_comp_model (
  input wire logic clk,
  input wire logic sampleHold,
  input wire logic comparatorPower,
  input wire sarc_pkg::sarc_code_t trialCode,
  input wire logic [7:0] channelOneHot,
  input wire logic [7:0][9:0] analogIn,
  output logic compResultAsync
);
  // ----------------------------------------------------------------------
  // held level and noise source
  // ----------------------------------------------------------------------
  sarc_pkg::sarc_code_t heldLevel = 10'h000; // frozen sample
  logic noise = 1'b0; // toggles so an unpowered comparator gives junk

  // track the selected pin while sampling, freeze while holding
  always @(posedge clk)
  begin
    noise <= ~noise;
    for (int k = 0; k < 8; k++)
      if (sampleHold && channelOneHot[k])
        heldLevel <= analogIn[k];
  end

  // decision: keep the trial bit while the sample is not below the tap
  assign compResultAsync = comparatorPower ?
    (heldLevel >= trialCode) : noise;
endmodule

/* File: sarc_consts.svh */
// named constants of the successive-approximation converter controller
// assumes a 16-bit register address space and 8-bit control registers
`ifndef SARC_CONSTS_SVH
`define SARC_CONSTS_SVH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define SARC_ADDR_MODE 16'hff8d
`define SARC_ADDR_RES_WIDE 16'hff1e
`define SARC_ADDR_RES_HIGH 16'hff1f
`define SARC_ADDR_CHAN 16'hff8e
`define SARC_ADDR_PINCFG 16'hff8f
`define SARC_ADDR_PINFUNC 16'hff90
`define SARC_ADDR_PINDIR 16'hff22
`define SARC_ADDR_STATUS 16'hff91

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SARC_RST_MODE 8'h00
`define SARC_RST_CHAN 3'h0
`define SARC_RST_PINCFG 8'h00
`define SARC_RST_PINFUNC 8'h00
`define SARC_RST_PINDIR 8'hff
`define SARC_RST_CODE 10'h000

// ----------------------------------------------------------------------
// mode register field positions
// ----------------------------------------------------------------------
`define SARC_MODE_RUN 7
`define SARC_MODE_FR_HI 6
`define SARC_MODE_FR_LO 3
`define SARC_MODE_LV_HI 2
`define SARC_MODE_LV_LO 1
`define SARC_MODE_CMP 0

// ----------------------------------------------------------------------
// conversion timing, in conversion-clock steps
// ----------------------------------------------------------------------
`define SARC_RES_BITS 10
`define SARC_MSB_IDX 4'h9
`define SARC_LSB_IDX 4'h0
`define SARC_FAD_LEN_LV0 22
`define SARC_FAD_LEN_LV1 40
`define SARC_LOAD_STEPS 1
`define SARC_RES_PAD 6

// conversion clock divisors per frequency-select code
`define SARC_DIV_FR3 5'h10
`define SARC_DIV_0000 5'h0c
`define SARC_DIV_0001 5'h08
`define SARC_DIV_0010 5'h06
`define SARC_DIV_0011 5'h04
`define SARC_DIV_0100 5'h03
`define SARC_DIV_0101 5'h02

// ----------------------------------------------------------------------
// clock rate and comparator settling time
// ----------------------------------------------------------------------
`define SARC_CLK_MHZ 250
`define SARC_COMP_SETTLE_NS 1000
`define SARC_NS_PER_US 1000

`endif

/* File: sarc_pkg.sv */
// types shared by the converter controller files
// assumes sarc_consts.svh holds every number
package sarc_pkg;

  // ----------------------------------------------------------------------
  // register bus request
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;  // register address
    logic [15:0] wdata; // write data, control data in low byte
    logic [7:0] wmask;  // bit mask for single-bit or byte writes
    logic wr;           // one-cycle write strobe
    logic rd;           // one-cycle read strobe
  } sarc_bus_req_s;

  // conversion sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_BITS,
    ST_LOAD
  } sarc_state_e;

  // approximation code
  typedef logic [9:0] sarc_code_t;

endpackage

/* File: sarc_pkg_unused_guard.sv */
// intentionally empty
`timescale 1ns/10ps

/* File: sarc_step_timer.sv */
// conversion clock divider: one tick every divisor cycles while running
// assumes divisor is at least 2 and stays fixed while run is high
`timescale 1ns/10ps
module sarc_step_timer #(
  parameter int DIV_W = 5
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic run,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);

  logic [DIV_W-1:0] cnt_reg; // cycle count within one step

  // ----------------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------------
  // counts from run onward, restarts whenever run drops
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!run)
      begin
        // stopped: hold counter at start
        cnt_reg <= '0;
        tick <= 1'b0;
      end
      else if (cnt_reg == DIV_W'(divisor - 1'b1))
      begin
        // end of step
        cnt_reg <= '0;
        tick <= 1'b1;
      end
      else
      begin
        cnt_reg <= DIV_W'(cnt_reg + 1'b1);
        tick <= 1'b0;
      end
    end
  end

endmodule

/* File: sarc_tb.sv */
// self-checking bench of the converter controller with front-end model
// assumes the register map and timing of sarc_consts.svh
`timescale 1ns/10ps
`include "sarc_consts.svh"
module tb;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic clk = 1'b0; // 250 MHz
  logic reset = 1'b1; // synchronous, active high
  logic clkEn = 1'b1;
  sarc_pkg::sarc_bus_req_s busReq = '0; // register bus request
  logic [15:0] busRdata;
  logic busWait;
  logic compResultAsync;
  logic sampleHold;
  logic comparatorPower;
  sarc_pkg::sarc_code_t trialCode;
  logic [7:0] channelOneHot;
  logic [7:0] pinAnalogMode;
  logic [7:0] pinFunction;
  logic [7:0] pinDirection;
  logic conversionDoneIrq;
  logic [7:0][9:0] analogIn = '0; // pin levels as codes
  logic rdDly = 1'b0; // read taken at the last edge
  logic [16:0] notes[$]; // expected {wait, data} per read
  logic [16:0] note;
  logic [3:0] frTab [5] = '{4'h8, 4'h0, 4'h1, 4'h2, 4'h3}; // divider codes
  int divTab [5] = '{16, 12, 8, 6, 4}; // clocks per step for frTab
  int miscompares = 0;
  int checks = 0;
  int n;
  logic [2:0] ch;
  sarc_pkg::sarc_code_t code;

  always #2 clk = ~clk;

  sarc_adc_controller dut (.clk(clk), .reset(reset), .clkEn(clkEn),
    .busReq(busReq), .busRdata(busRdata), .busWait(busWait),
    .compResultAsync(compResultAsync), .sampleHold(sampleHold),
    .comparatorPower(comparatorPower), .trialCode(trialCode),
    .channelOneHot(channelOneHot), .pinAnalogMode(pinAnalogMode),
    .pinFunction(pinFunction), .pinDirection(pinDirection),
    .conversionDoneIrq(conversionDoneIrq));

  sarc_comp_model model (.clk(clk), .sampleHold(sampleHold),
    .comparatorPower(comparatorPower), .trialCode(trialCode),
    .channelOneHot(channelOneHot), .analogIn(analogIn),
    .compResultAsync(compResultAsync));

  // ----------------------------------------------------------------------
  // compare, bus tasks, verdict
  // ----------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one-cycle write, then look at the wait pulse
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
    input logic [7:0] m, input logic w);
    @(posedge clk);
    busReq <= '{addr: a, wdata: {8'h00, d}, wmask: m, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
    #1;
    chk("busWait", busWait, w);
  endtask

  // one-cycle read; the monitor compares the data
  task automatic rd(input logic [15:0] a, input logic [15:0] d,
    input logic w);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 16'h0000, wmask: 8'h00, wr: 1'b0, rd: 1'b1};
    notes.push_back({w, d});
    @(posedge clk);
    busReq.rd <= 1'b0;
  endtask

  // cycles until the next completion pulse, bounded
  task automatic wait_irq(output int cnt);
    cnt = 0;
    do
    begin
      @(posedge clk);
      cnt++;
    end
    while (conversionDoneIrq !== 1'b1 && cnt < 2000);
  endtask

  task automatic end_sim();
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // read data stand in the cycle after the strobe
  always @(posedge clk)
    rdDly <= busReq.rd;

  // oldest note against what the read returned
  always @(negedge clk)
    if (rdDly === 1'b1 && notes.size() > 0)
    begin
      note = notes.pop_front();
      chk("busRdata", busRdata, note[15:0]);
      chk("readWait", busWait, note[16]);
    end

  // watchdog against a hang
  initial
  begin
    #80000;
    miscompares++;
    end_sim();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(5549));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    // reset values and an unmapped place
    rd(`SARC_ADDR_MODE, 16'h0000, 1'b0);
    rd(`SARC_ADDR_RES_WIDE, 16'h0000, 1'b1);
    rd(`SARC_ADDR_RES_HIGH, 16'h0000, 1'b1);
    rd(16'h0100, 16'h0000, 1'b0);
    chk("pinDirection", pinDirection, 8'hff);
    wr(`SARC_ADDR_PINCFG, 8'h5a, 8'h00, 1'b0);
    chk("pinAnalogMode", pinAnalogMode, 8'h5a);
    // comparator alone via a single-bit write, settled before running
    wr(`SARC_ADDR_MODE, 8'hff, 8'h01, 1'b1);
    // the comparator output follows the mode register one cycle later
    repeat (2) @(negedge clk);
    chk("comparatorPower", comparatorPower, 1'b1);
    rd(`SARC_ADDR_MODE, 16'h0001, 1'b0);
    repeat (260) @(posedge clk);
    // five divider codes, both level settings, random pin and levels
    for (int i = 0; i < 5; i++)
    begin
      ch = 3'($urandom % 8);
      for (int k = 0; k < 8; k++)
        analogIn[k] = 10'($urandom);
      code = analogIn[ch];
      wr(`SARC_ADDR_CHAN, {5'h00, ch}, 8'($urandom), 1'b0);
      wr(`SARC_ADDR_MODE, {1'b1, frTab[i], 1'b0, i[0], 1'b1}, 8'hff,
        1'b1);
      wait_irq(n);
      wait_irq(n);
      chk("period", n, (i[0] ? 40 : 22) * divTab[i]);
      chk("channelOneHot", channelOneHot, 8'h01 << ch);
      rd(`SARC_ADDR_RES_WIDE, {code, 6'h00}, 1'b1);
      rd(`SARC_ADDR_RES_HIGH, {8'h00, code[9:2]}, 1'b1);
      wr(`SARC_ADDR_MODE, 8'h01, 8'hff, 1'b1);
      // the channel output drops one cycle after the run bit
      repeat (2) @(negedge clk);
      chk("channelStopped", channelOneHot, 8'h00);
    end
    // stopped: results held, writes to them ignored, no completions
    wr(`SARC_ADDR_RES_WIDE, 8'h00, 8'hff, 1'b0);
    rd(`SARC_ADDR_RES_WIDE, {code, 6'h00}, 1'b1);
    wait_irq(n);
    chk("noIrq", n, 2000);
    // stopped, settled comparator, last result reliable
    rd(`SARC_ADDR_STATUS, 16'h0001, 1'b0);
    // converting with the comparator off marks the result unreliable
    wr(`SARC_ADDR_MODE, 8'h80, 8'hff, 1'b1);
    wait_irq(n);
    rd(`SARC_ADDR_STATUS, 16'h0006, 1'b0);
    end_sim();
  end
endmodule
